/* pkg/hpp_pkg.sv */
// Constants and types for the host parallel register port.
// Assumes a single 40 MHz system clock and an 8-bit register space behind the port.
// Overview of operation
// R1: Mode high times accesses from host clock; low uses internal timing.
// R2: Host supplies a continuous square-wave interface clock in synchronous mode.
// R3: Access starts only with select low; select high ignores all strobes.
// R4: Write strobe while selected stores data bus into addressed register.
// R5: Read strobe while selected returns addressed register contents to host.
// R6: Ready driven low marks completion; host waits for it before ending.
// R7: An 8-bit direct, non-multiplexed address selects each access target.
// R8: Factory test input held low by host; treated low when undriven.
// R9: Data bus is bidirectional: host drives on writes, device on reads.
// R10: Device drives data bus only while select and read strobe asserted.
package hpp_pkg;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 8;
	localparam int SYS_CLK_HZ = 40000000;
	// Internal access time in asynchronous mode, in ns
	localparam int ASYNC_ACCESS_NS = 100;
	localparam int ASYNC_ACCESS_CYC =
		(ASYNC_ACCESS_NS * (SYS_CLK_HZ / 1000000) + 999) / 1000;
	localparam logic [3:0] ASYNC_CNT_INIT = 4'(ASYNC_ACCESS_CYC);
	// Host clock rising edges an access waits in synchronous mode
	localparam logic [3:0] SYNC_EDGES = 4'h2;
	localparam logic [7:0] RESET_DATA = 8'h00;
	// Idle levels of {mode, host clock, select, write, read, test} after reset
	localparam logic [5:0] CTL_IDLE = 6'h0E;
	typedef enum logic [2:0] {HPP_IDLE, HPP_WAIT, HPP_DONE} hpp_state_t;
endpackage : hpp_pkg

/* rtl/hpp_port.sv */
// Host parallel register port: pin-side handshake and register file strobes.
// Assumes host pins are asynchronous to i_mclk; register file answers in one cycle.
`timescale 1ns/1ps
`default_nettype none
module hpp_port (
	input  wire logic                       i_mclk,
	input  wire logic                       i_rstn,
	input  wire logic                       i_pmode,
	input  wire logic                       i_pclk,
	input  wire logic                       i_cs_n,
	input  wire logic                       i_wr_n,
	input  wire logic                       i_rd_n,
	input  wire logic [hpp_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [hpp_pkg::DATA_W-1:0] i_data,
	input  wire logic                       i_test,
	output logic      [hpp_pkg::DATA_W-1:0] o_data,
	output logic                            o_data_oe,
	output logic                            o_rdy_n,
	output logic                            o_rdy_oe,
	output logic                            o_reg_we,
	output logic                            o_reg_re,
	output logic      [hpp_pkg::ADDR_W-1:0] o_reg_addr,
	output logic      [hpp_pkg::DATA_W-1:0] o_reg_wdata,
	input  wire logic [hpp_pkg::DATA_W-1:0] i_reg_rdata,
	output logic                            o_test_mode
);
	import hpp_pkg::*;

	// Reset release and synchronised pin copies
	logic       rst_m_reg;
	logic       rst_s_reg;
	logic       rstn_int;
	logic [5:0] ctl_s;
	logic [ADDR_W-1:0] addr_s;
	logic [DATA_W-1:0] data_s;
	logic       pmode_s;
	logic       pclk_s;
	logic       cs_n_s;
	logic       wr_n_s;
	logic       rd_n_s;
	logic       test_s;

	// Reset release through two flip-flops
	// so that every register below leaves reset on the same edge
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_m_reg <= 1'b0;
			rst_s_reg <= 1'b0;
		end else begin
			rst_m_reg <= 1'b1;
			rst_s_reg <= rst_m_reg;
		end
	end
	assign rstn_int = rst_s_reg;

	// Control pins synchronised; select and strobes reset to their idle high level
	hpp_sync2 #(.W(6), .INIT(CTL_IDLE)) u_sync_ctl (
		.i_mclk (i_mclk),
		.i_rstn (rstn_int),
		.i_d    ({i_pmode, i_pclk, i_cs_n, i_wr_n, i_rd_n, i_test}),
		.o_q    (ctl_s)
	);
	// Address and data synchronised
	hpp_sync2 #(.W(ADDR_W + DATA_W)) u_sync_bus (
		.i_mclk (i_mclk),
		.i_rstn (rstn_int),
		.i_d    ({i_addr, i_data}),
		.o_q    ({addr_s, data_s})
	);
	assign pmode_s = ctl_s[5];
	assign pclk_s  = ctl_s[4];
	assign cs_n_s  = ctl_s[3];
	assign wr_n_s  = ctl_s[2];
	assign rd_n_s  = ctl_s[1];
	assign test_s  = ctl_s[0];

	// Sequencer state, latched access and pin-side registers
	hpp_state_t        state_reg, state_next;
	logic [3:0]        cnt_reg, cnt_next;
	logic              pclk_reg, pclk_next;
	logic              wr_reg, wr_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic [DATA_W-1:0] wdat_reg, wdat_next;
	logic [DATA_W-1:0] rdat_reg, rdat_next;
	logic              we_reg, we_next;
	logic              re_reg, re_next;
	logic              rdy_reg, rdy_next;
	logic              oe_reg, oe_next;
	logic              test_reg, test_next;
	// Decoded strobes and access timebase
	logic              sel_wr;
	logic              sel_rd;
	logic              pclk_rise;
	logic              tick;

	// Strobes count only while selected
	assign sel_wr    = !cs_n_s && !wr_n_s; // R3
	assign sel_rd    = !cs_n_s && !rd_n_s; // R3
	// Host clock edge detector resets low, as does its synchronised copy
	assign pclk_rise = pclk_s && !pclk_reg;
	// Access timebase: host clock edges or internal cycles
	assign tick      = i_pmode_sel(pmode_s, pclk_rise); // R1

	// Picks the timebase: host clock rising edges or every internal cycle
	function automatic logic i_pmode_sel(input logic mode, input logic edge_seen);
		i_pmode_sel = mode ? edge_seen : 1'b1;
	endfunction : i_pmode_sel

	// Next-state logic of the access sequencer.
	// One asynchronous access, in i_mclk edges after the host pins change:
	//   third edge    synchronised select and strobe seen, address and data taken
	//   seventh edge  one-cycle register file strobe after four internal cycles
	//   eighth edge   register file read data valid on i_reg_rdata, copied on the next edge
	//   ninth edge    ready pulled low together with valid read data
	// Ready stands until the host's release is seen through the synchronisers.
	// A strobe released while still waiting aborts the access; nothing is stored.
	// Both strobes low together are taken as a write.
	always_comb begin
		state_next = state_reg;
		cnt_next   = cnt_reg;
		pclk_next  = pclk_s;
		wr_next    = wr_reg;
		addr_next  = addr_reg;
		wdat_next  = wdat_reg;
		rdat_next  = rdat_reg;
		we_next    = 1'b0;
		re_next    = 1'b0;
		rdy_next   = rdy_reg;
		oe_next    = sel_rd; // R10
		test_next  = test_s; // R8
		case (state_reg)
			HPP_IDLE: begin
				rdy_next = 1'b0;
				if (sel_wr || sel_rd) begin // R3
					state_next = HPP_WAIT;
					wr_next    = sel_wr;
					addr_next  = addr_s; // R7
					wdat_next  = data_s; // R9
					cnt_next   = pmode_s ? SYNC_EDGES : ASYNC_CNT_INIT; // R1
				end
			end
			HPP_WAIT: begin
				if (!(sel_wr || sel_rd)) begin
					state_next = HPP_IDLE; // Aborted access
				end else if (tick) begin
					// Last count: strobe the register file for exactly one cycle
					if (cnt_reg <= 4'h1) begin
						state_next = HPP_DONE;
						we_next    = wr_reg; // R4
						re_next    = !wr_reg; // R5
					end else begin
						cnt_next = cnt_reg - 4'h1;
					end
				end
			end
			HPP_DONE: begin
				if (we_reg || re_reg) begin
					// Strobe cycle: the register file has not answered yet
					rdy_next = 1'b0;
				end else begin
					if (!wr_reg && !rdy_reg) begin
						rdat_next = i_reg_rdata; // R5
					end
					rdy_next = 1'b1; // R6
				end
				if (!(sel_wr || sel_rd)) begin
					state_next = HPP_IDLE;
					rdy_next   = 1'b0;
				end
			end
			default: begin
				state_next = HPP_IDLE;
			end
		endcase
	end

	// State registers
	// Reset branch loads constants only; otherwise the next values are registered
	always_ff @(posedge i_mclk or negedge rstn_int) begin
		if (!rstn_int) begin
			state_reg <= HPP_IDLE;
			cnt_reg   <= 4'h0;
			pclk_reg  <= 1'b0;
			wr_reg    <= 1'b0;
			addr_reg  <= '0;
			wdat_reg  <= RESET_DATA;
			rdat_reg  <= RESET_DATA;
			we_reg    <= 1'b0;
			re_reg    <= 1'b0;
			rdy_reg   <= 1'b0;
			oe_reg    <= 1'b0;
			test_reg  <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg   <= cnt_next;
			pclk_reg  <= pclk_next;
			wr_reg    <= wr_next;
			addr_reg  <= addr_next;
			wdat_reg  <= wdat_next;
			rdat_reg  <= rdat_next;
			we_reg    <= we_next;
			re_reg    <= re_next;
			rdy_reg   <= rdy_next;
			oe_reg    <= oe_next;
			test_reg  <= test_next;
		end
	end

	// Pin and register-file outputs
	// The bus enable also follows the raw pins so that the bus is freed at once
	// when the host releases select or the read strobe
	assign o_data      = rdat_reg;
	assign o_data_oe   = oe_reg && !i_cs_n && !i_rd_n; // R10
	assign o_rdy_n     = 1'b0; // R6
	assign o_rdy_oe    = rdy_reg; // Open drain: pull low when done
	assign o_reg_we    = we_reg;
	assign o_reg_re    = re_reg;
	assign o_reg_addr  = addr_reg;
	assign o_reg_wdata = wdat_reg;
	assign o_test_mode = test_reg;
endmodule : hpp_port
`default_nettype wire

/* rtl/hpp_sync2.sv */
// Two-flip-flop synchroniser for pin inputs.
// Assumes the destination clock and an active-low asynchronous reset.
`timescale 1ns/1ps
`default_nettype none
module hpp_sync2 #(
	parameter int           W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         i_mclk,
	input  wire logic         i_rstn,
	input  wire logic [W-1:0] i_d,
	output logic      [W-1:0] o_q
);
	logic [W-1:0] meta_reg;
	logic [W-1:0] q_reg;
	// First stage read only by the second stage; both reset to the idle level
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_reg <= INIT;
			q_reg    <= INIT;
		end else begin
			meta_reg <= i_d;
			q_reg    <= meta_reg;
		end
	end
	assign o_q = q_reg;
endmodule : hpp_sync2
`default_nettype wire

/* sim/hpp_host.sv */
// Host model: drives select, strobes, address and write data of the port.
// Assumes the bench resolves the pulled-up ready pin and the shared data bus.
`timescale 1ns/1ps
`default_nettype none
module hpp_host (
	input  wire logic       i_mclk,
	input  wire logic       i_rdy_n,
	input  wire logic [7:0] i_bus,
	output logic            o_pclk,
	output logic            o_cs_n,
	output logic            o_wr_n,
	output logic            o_rd_n,
	output logic            o_oe,
	output logic [7:0]      o_addr,
	output logic [7:0]      o_d
);
	logic ph = 0;
	initial {o_pclk, o_cs_n, o_wr_n, o_rd_n, o_oe, o_addr, o_d} = 21'h0E0000;
	// Continuous square host clock, four system cycles a period
	always @(posedge i_mclk) begin
		ph <= ~ph;
		if (ph) o_pclk <= ~o_pclk;
	end
	// One access; held until ready is seen low or 80 cycles pass, then released together
	task automatic access(input logic sel, wr, input logic [7:0] a, d,
		output logic [7:0] q, output logic ok);
		int n;
		@(posedge i_mclk);
		o_cs_n <= !sel;
		o_wr_n <= !wr;
		o_rd_n <= wr;
		o_oe <= wr;
		o_addr <= a;
		o_d <= d;
		n = 0;
		ok = 0;
		while (n < 80 && !ok) begin
			@(posedge i_mclk);
			n++;
			ok = (i_rdy_n === 1'b0);
		end
		q = i_bus;
		{o_cs_n, o_wr_n, o_rd_n, o_oe} <= 4'hE;
		repeat (4) @(posedge i_mclk);
	endtask : access
endmodule : hpp_host
`default_nettype wire

/* sim/hpp_port_assertions.sv */
// Checker for the host parallel port, bound to its pins.
// Assumes the host holds select and strobe until ready is seen.
`timescale 1ns/1ps
`default_nettype none
module hpp_port_chk (
	input  wire logic       i_mclk,
	input  wire logic       i_rstn,
	input  wire logic       i_cs_n,
	input  wire logic       i_wr_n,
	input  wire logic       i_rd_n,
	input  wire logic [7:0] i_addr,
	input  wire logic [7:0] i_data,
	input  wire logic [7:0] o_reg_addr,
	input  wire logic [7:0] o_reg_wdata,
	input  wire logic       o_data_oe,
	input  wire logic       o_rdy_n,
	input  wire logic       o_rdy_oe,
	input  wire logic       o_reg_we,
	input  wire logic       o_reg_re
);
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);
	property p_oe;
		o_data_oe |-> !i_cs_n && !i_rd_n && !$past(i_cs_n, 3) && !$past(i_rd_n, 3);
	endproperty
	a_oe: assert property (p_oe) else $error("bus driven outside a read");
	property p_idle; i_cs_n [*4] |-> !o_reg_we && !o_reg_re && !o_rdy_oe; endproperty
	a_idle: assert property (p_idle) else $error("activity while deselected");
	property p_we; o_reg_we |-> !i_cs_n && !i_wr_n && o_reg_wdata == i_data; endproperty
	a_we: assert property (p_we) else $error("bad register store");
	property p_re; o_reg_re |-> !i_cs_n && !i_rd_n && i_wr_n; endproperty
	a_re: assert property (p_re) else $error("bad register fetch");
	property p_addr; o_reg_we || o_reg_re |-> o_reg_addr == i_addr; endproperty
	a_addr: assert property (p_addr) else $error("register address differs");
	property p_pulse; o_reg_we || o_reg_re |=> !o_reg_we && !o_reg_re; endproperty
	a_pulse: assert property (p_pulse) else $error("access repeated");
	property p_done;
		$rose(o_rdy_oe) |-> $past(o_reg_we, 2) || $past(o_reg_re, 2);
	endproperty
	a_done: assert property (p_done) else $error("ready without access");
	property p_low; o_rdy_oe |-> !o_rdy_n && !$past(i_cs_n, 3); endproperty
	a_low: assert property (p_low) else $error("ready level wrong");
	c_we: cover property (o_reg_we);
	c_re: cover property (o_reg_re);
	c_rdy: cover property ($rose(o_rdy_oe));
endmodule : hpp_port_chk
bind hpp_port hpp_port_chk i_hpp_port_chk (.*);
`default_nettype wire

/* sim/tb.sv */
// Testbench for the host parallel port with host model and register file.
// Assumes a 40 MHz system clock and byte registers answering one cycle late.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import hpp_pkg::*;
	logic i_mclk = 0, i_rstn = 0, i_pmode = 0, i_test = 0;
	logic pclk, cs_n, wr_n, rd_n, h_oe, rdy, ok;
	logic [7:0] h_a, h_d, bus, o_data, o_reg_addr, o_reg_wdata, rdat, q;
	logic o_data_oe, o_rdy_n, o_rdy_oe, o_reg_we, o_reg_re, o_test_mode;
	logic [7:0] mem [256];
	int mismatches = 0, n_tests = 0;
	always #12.5 i_mclk = ~i_mclk;
	// Pulled-up ready; released bus shows the inverse of the last host value
	assign rdy = o_rdy_oe ? o_rdy_n : 1'b1;
	assign bus = h_oe ? h_d : (o_data_oe ? o_data : ~h_d);
	// Register file behind the port
	always @(posedge i_mclk) begin
		if (o_reg_we) mem[o_reg_addr] <= o_reg_wdata;
		if (o_reg_re) rdat <= mem[o_reg_addr];
	end
	hpp_port i_hpp_port (.i_mclk, .i_rstn, .i_pmode, .i_pclk(pclk), .i_cs_n(cs_n),
		.i_wr_n(wr_n), .i_rd_n(rd_n), .i_addr(h_a), .i_data(bus), .i_test, .o_data,
		.o_data_oe, .o_rdy_n, .o_rdy_oe, .o_reg_we, .o_reg_re, .o_reg_addr,
		.o_reg_wdata, .i_reg_rdata(rdat), .o_test_mode);
	hpp_host i_hpp_host (.i_mclk, .i_rdy_n(rdy), .i_bus(bus), .o_pclk(pclk),
		.o_cs_n(cs_n), .o_wr_n(wr_n), .o_rd_n(rd_n), .o_oe(h_oe), .o_addr(h_a), .o_d(h_d));
	task automatic check(input logic [7:0] seen, exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize;
		$display("mismatches=%0d n_tests=%0d", mismatches, n_tests);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : summarize
	// Writes then reads back the lowest and highest address in one mode
	task automatic t_rw(input logic m);
		@(posedge i_mclk) i_pmode <= m;
		repeat (4) @(posedge i_mclk);
		for (int k = 0; k < 4; k++) begin
			i_hpp_host.access(1, k < 2, k[0] ? 8'hFF : 8'h00, {7'h1E, m} ^ k[0], q, ok);
			check(ok, 1);
			if (k > 1) check(q, {7'h1E, m} ^ k[0]);
			check(o_data_oe, 0);
		end
	endtask : t_rw
	// Write strobe with select high: no answer, register keeps its value
	task automatic t_cs;
		i_hpp_host.access(0, 1, 8'hFF, 8'h55, q, ok);
		check(ok, 0);
		i_hpp_host.access(1, 0, 8'hFF, 8'h00, q, ok);
		check(q, 8'h3C);
	endtask : t_cs
	// Test pin is carried to the test-mode flag
	task automatic t_test;
		@(posedge i_mclk) i_test <= 1;
		repeat (6) @(posedge i_mclk);
		check(o_test_mode, 1);
		i_test <= 0;
		repeat (6) @(posedge i_mclk);
		check(o_test_mode, 0);
	endtask : t_test
	initial begin
		repeat (20) @(posedge i_mclk);
		i_rstn <= 1;
		repeat (6) @(posedge i_mclk);
		t_rw(0);
		t_rw(1);
		t_cs;
		t_test;
		summarize;
	end
	// Watchdog well beyond the expected run
	initial begin
		#100us;
		mismatches++;
		summarize;
	end
endmodule : tb
`default_nettype wire
